// ===== src/scg_params.svh
// constants of the system clock switch, divider and gate block
// assumes inclusion by bare name from the block's source files
`ifndef SCG_PARAMS_SVH
`define SCG_PARAMS_SVH
`define SCG_ADDR_SRC_CHOICE 32'h40048070
`define SCG_ADDR_SWITCH_STROBE 32'h40048074
`define SCG_ADDR_SYS_DIVIDER 32'h40048078
`define SCG_ADDR_BLOCK_GATES 32'h40048080
`define SCG_RST_SRC_CHOICE 2'h0
`define SCG_RST_SWITCH_STROBE 1'h1
`define SCG_RST_SYS_DIVIDER 8'h01
`define SCG_RST_BLOCK_GATES 8'h3f
`define SCG_COMMIT_BIT 0
`define SCG_GATE_CORE_BIT 0
`define SCG_GATE_WIDTH 8
`define SCG_DIV_WIDTH 8
`define SCG_SRC_WIDTH 2
`define SCG_NUM_SRC 4
`endif

// ===== src/scg_pkg.sv
// types of the system clock switch, divider and gate block
// assumes nothing beyond the params header
package scg_pkg;
	typedef enum logic [1:0] {
		SRC_INTERNAL_RC,
		SRC_PLL_INPUT,
		SRC_WATCHDOG_OSC,
		SRC_PLL_OUTPUT
	} scg_src_t;
	typedef enum logic [1:0] {
		BUS_IDLE,
		BUS_WRITE,
		BUS_READ
	} scg_bus_t;
endpackage

// ===== src/scg_div_if.sv
// carrier between the clock control top and its system clock divider
// assumes both ends share clk
`timescale 1ns/1ps
`default_nettype none
`include "scg_params.svh"
interface scg_div_if;
	logic mainTick;
	logic [`SCG_DIV_WIDTH-1:0] divValue;
	logic sysTick;
	modport ctrl (output mainTick, output divValue, input sysTick);
	modport div (input mainTick, input divValue, output sysTick);
endinterface
`default_nettype wire

// ===== src/scg_sys_divider.sv
// divider that turns main clock ticks into system clock ticks
// assumes main clock ticks are one-cycle enables on clk
`timescale 1ns/1ps
`default_nettype none
`include "scg_params.svh"
module scg_sys_divider
	import scg_pkg::*;
#(
	parameter int DIV_WIDTH = `SCG_DIV_WIDTH
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// divider link
	scg_div_if.div link
);
	typedef struct packed {
		logic [DIV_WIDTH-1:0] count;
		logic [DIV_WIDTH-1:0] active;
		logic tick;
	} scg_div_state_t;

	scg_div_state_t st_q, st_d;

	// the link carries a fixed width, so any other width is refused at elaboration
	if (DIV_WIDTH != `SCG_DIV_WIDTH) begin
		$error("divider width must match the link");
	end

	always_comb begin
		st_d = st_q;
		st_d.tick = 1'b0;
		if (link.mainTick) begin
			if (st_q.active == '0) begin
				// stopped: pick up a new value at once so a restart is clean
				st_d.active = link.divValue;
				st_d.count = '0;
			end else if (st_q.count + 1'b1 == st_q.active) begin
				// new divide value only at a period end, so no runt period
				st_d.tick = 1'b1;
				st_d.count = '0;
				st_d.active = link.divValue;
			end else begin
				st_d.count = st_q.count + 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_q <= '{count: '0, active: `SCG_RST_SYS_DIVIDER, tick: 1'b0};
		end else begin
			st_q <= st_d;
		end
	end

	assign link.sysTick = st_q.tick;
endmodule
`default_nettype wire

// ===== src/scg_clock_ctrl.sv
// clock source switch, system clock divider and per-block clock gates
// assumes ahb-lite master with single word transfers; clocks are one-cycle enables on clk
// How it works
// - the strobe register holds one bit at bit 0 resetting to 1, writing 0 then 1 commits, upper bits read zero.
// - the source choice codes 0 rc oscillator, 1 pll input, 2 watchdog oscillator, 3 pll output, reset rc.
// - the main clock is divided by the divider value to give the system clock.
// - divide values 1 to 255 divide by themselves and 0 stops the system clock.
// - the divide field resets to 1 and bits 31:8 read zero.
// - gate bit 0 for the core and bus fabric is read only and always 1.
// - gate bit 1 enables the boot rom clock and resets to 1.
// - gate bit 2 enables the main sram clock and resets to 1.
// - gate bit 3 enables the flash register interface clock and resets to 1.
// - gate bit 4 enables the flash array clock and resets to 1.
// - gate bit 5 enables the i2c clock and resets to 1.
// - gate bit 6 enables the gpio clock and resets to 0.
// - gate bit 7 enables the first 16-bit timer clock and resets to 0.
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "scg_params.svh"
module scg_clock_ctrl
	import scg_pkg::*;
#(
	parameter int GATE_WIDTH = `SCG_GATE_WIDTH
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// source clock ticks, one bit per source code
	input wire logic [`SCG_NUM_SRC-1:0] srcTick,
	// clock outputs
	output logic [`SCG_SRC_WIDTH-1:0] mainSrcActive,
	output logic mainClkTick,
	output logic sysClkTick,
	output logic [GATE_WIDTH-1:0] blockClkTick
);
	typedef struct packed {
		scg_bus_t phase;
		logic [31:0] addr;
		logic [31:0] rdata;
		logic ready;
		scg_src_t choice;
		scg_src_t active;
		logic strobe;
		logic [`SCG_DIV_WIDTH-1:0] divider;
		logic [GATE_WIDTH-1:0] gates;
		logic [GATE_WIDTH-1:0] gatesLive;
		logic mainTick;
		logic sysTick;
		logic [GATE_WIDTH-1:0] blockTick;
	} scg_ctrl_state_t;

	scg_ctrl_state_t st_q, st_d;
	scg_div_if divLink();

	// register map and reset value cover exactly eight gates, so other widths are refused at elaboration
	if (GATE_WIDTH != `SCG_GATE_WIDTH) begin
		$error("gate width must be 8");
	end

	// bit 0 is forced high whatever software writes
	function automatic logic [GATE_WIDTH-1:0] fixGates(input logic [GATE_WIDTH-1:0] raw);
		logic [GATE_WIDTH-1:0] g;
		g = raw;
		g[`SCG_GATE_CORE_BIT] = 1'b1;
		return g;
	endfunction

	function automatic logic [31:0] readReg(input logic [31:0] a, input scg_ctrl_state_t s);
		logic [31:0] r;
		r = 32'h00000000;
		case (a)
			`SCG_ADDR_SRC_CHOICE: r[`SCG_SRC_WIDTH-1:0] = s.choice;
			`SCG_ADDR_SWITCH_STROBE: r[`SCG_COMMIT_BIT] = s.strobe;
			`SCG_ADDR_SYS_DIVIDER: r[`SCG_DIV_WIDTH-1:0] = s.divider;
			`SCG_ADDR_BLOCK_GATES: r[GATE_WIDTH-1:0] = fixGates(s.gates);
			default: r = 32'h00000000;
		endcase
		return r;
	endfunction

	always_comb begin
		st_d = st_q;
		st_d.ready = 1'b1;
		// data phase of a write taken on the previous edge
		if (st_q.phase == BUS_WRITE) begin
			case (st_q.addr)
				`SCG_ADDR_SRC_CHOICE: st_d.choice = scg_src_t'(hwdata[`SCG_SRC_WIDTH-1:0]);
				`SCG_ADDR_SWITCH_STROBE: begin
					st_d.strobe = hwdata[`SCG_COMMIT_BIT];
					// a low write arms, the following high write commits
					if (hwdata[`SCG_COMMIT_BIT] && !st_q.strobe) begin
						st_d.active = st_q.choice;
					end
				end
				`SCG_ADDR_SYS_DIVIDER: st_d.divider = hwdata[`SCG_DIV_WIDTH-1:0];
				`SCG_ADDR_BLOCK_GATES: st_d.gates = fixGates(hwdata[GATE_WIDTH-1:0]);
				default: st_d.gates = st_q.gates;
			endcase
		end
		// address phase
		st_d.phase = BUS_IDLE;
		st_d.rdata = 32'h00000000;
		if (hsel && htrans[1] && hready) begin
			st_d.addr = haddr;
			if (hwrite) begin
				st_d.phase = BUS_WRITE;
			end else begin
				st_d.phase = BUS_READ;
				st_d.rdata = readReg(haddr, st_q);
			end
		end
		// source ticks are pulses in one domain, so a switch cannot split a tick
		st_d.mainTick = srcTick[st_q.active];
		st_d.sysTick = divLink.sysTick;
		// gates sampled only with a system tick, so a gated tick is never cut short
		if (divLink.sysTick) begin
			st_d.gatesLive = st_q.gates;
		end
		// gates in use for this tick are those latched before it
		st_d.blockTick = divLink.sysTick ? st_q.gatesLive : '0;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_q <= '{phase: BUS_IDLE, addr: 32'h00000000, rdata: 32'h00000000, ready: 1'b1,
				choice: SRC_INTERNAL_RC, active: SRC_INTERNAL_RC, strobe: `SCG_RST_SWITCH_STROBE,
				divider: `SCG_RST_SYS_DIVIDER, gates: `SCG_RST_BLOCK_GATES,
				gatesLive: `SCG_RST_BLOCK_GATES, mainTick: 1'b0, sysTick: 1'b0, blockTick: '0};
		end else begin
			st_q <= st_d;
		end
	end

	assign divLink.mainTick = st_q.mainTick;
	assign divLink.divValue = st_q.divider;

	scg_sys_divider #(
		.DIV_WIDTH(`SCG_DIV_WIDTH)
	) u_div (
		.clk(clk),
		.sys_rst(sys_rst),
		.link(divLink)
	);

	assign hreadyout = st_q.ready;
	assign hrdata = st_q.rdata;
	assign hresp = 1'b0;
	assign mainSrcActive = st_q.active;
	assign mainClkTick = st_q.mainTick;
	assign sysClkTick = st_q.sysTick;
	assign blockClkTick = st_q.blockTick;
endmodule
`default_nettype wire

// ===== dv/scg_clock_ctrl_chk.sv
// checker for the clock switch, divider and gates
// assumes a bind onto the scg_clock_ctrl ports
`timescale 1ns/1ps
`default_nettype none
`include "scg_params.svh"
module scg_clock_ctrl_chk #(parameter int GATE_WIDTH = 8) (
	// clock, reset, bus
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	// clocks
	input wire logic [`SCG_NUM_SRC-1:0] srcTick,
	input wire logic [`SCG_SRC_WIDTH-1:0] mainSrcActive,
	input wire logic mainClkTick,
	input wire logic sysClkTick,
	input wire logic [GATE_WIDTH-1:0] blockClkTick
);
	logic wrTake, stbWr_q, srcWr_q, gateWr_q, divWr_q, stbVal_q;
	logic [1:0] srcVal_q;
	assign wrTake = hsel && htrans[1] && hready && hwrite && !sys_rst;
	// flags rise at the address phase, a cycle ahead of the write, so checks stay safe
	always_ff @(posedge clk) begin
		stbWr_q <= wrTake && haddr == `SCG_ADDR_SWITCH_STROBE;
		srcWr_q <= wrTake && haddr == `SCG_ADDR_SRC_CHOICE;
		gateWr_q <= !sys_rst && (gateWr_q || wrTake && haddr == `SCG_ADDR_BLOCK_GATES);
		divWr_q <= !sys_rst && (divWr_q || wrTake && haddr == `SCG_ADDR_SYS_DIVIDER);
		// shadows of the stored strobe bit and source choice, taken at the end of the write data phase
		stbVal_q <= sys_rst || (stbWr_q ? hwdata[0] : stbVal_q);
		srcVal_q <= sys_rst ? 2'h0 : (srcWr_q ? hwdata[1:0] : srcVal_q);
	end
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_core_always: assert property (blockClkTick[0] == sysClkTick) else $error("core tick");
	a_gate_subset: assert property ((blockClkTick & ~{GATE_WIDTH{sysClkTick}}) == '0) else $error("runt");
	a_main_follow: assert property (!$past(sys_rst) |-> mainClkTick == $past(srcTick[mainSrcActive]))
		else $error("main tick");
	a_sys_from_main: assert property (sysClkTick |-> $past(mainClkTick, 2)) else $error("sys tick");
	a_src_commit: assert property ($changed(mainSrcActive) |-> $past(stbWr_q && hwdata[0] && !stbVal_q))
		else $error("source switch");
	a_src_taken: assert property (stbWr_q && hwdata[0] && !stbVal_q |=> mainSrcActive == srcVal_q)
		else $error("source not taken");
	a_gates_on: assert property (!gateWr_q |-> blockClkTick[5:1] == {5{sysClkTick}})
		else $error("gate on");
	a_gates_off: assert property (!gateWr_q |-> blockClkTick[7:6] == 2'h0) else $error("gate off");
	// a main tick seen inside a reset must not demand a system tick after it
	a_div_one: assert property (!$past(sys_rst, 2) && !divWr_q && $past(mainClkTick, 2) |-> sysClkTick)
		else $error("div one");
	c_switch: cover property ($changed(mainSrcActive));
	c_top_gate: cover property (blockClkTick[7]);
	c_pll_out: cover property (mainSrcActive == 2'h3 && mainClkTick);
endmodule
`default_nettype wire

// ===== dv/tb_scg_clock_ctrl.sv
// self-checking bench for the clock switch, divider and gates
// assumes the design and checker files are compiled ahead of it
`timescale 1ns/1ps
`default_nettype none
`include "scg_params.svh"
module tb_scg_clock_ctrl;
	localparam logic [31:0] SRC = `SCG_ADDR_SRC_CHOICE;
	localparam logic [31:0] STB = `SCG_ADDR_SWITCH_STROBE;
	localparam logic [31:0] DIV = `SCG_ADDR_SYS_DIVIDER;
	localparam logic [31:0] GAT = `SCG_ADDR_BLOCK_GATES;
	logic clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, rnd = 1'b0, rdPend = 1'b0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata;
	logic [1:0] htrans = 2'h0, mainSrcActive;
	logic [3:0] srcTick = 4'hf;
	logic hreadyout, hresp, mainClkTick, sysClkTick;
	logic [7:0] blockClkTick, gates;
	logic [31:0] expQ[$];
	int n_fail = 0, n_checks = 0, sysCnt, expSys, blkCnt[8];
	int divs[5] = '{2, 3, 0, 1, 255};
	scg_clock_ctrl uut (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.srcTick(srcTick), .mainSrcActive(mainSrcActive), .mainClkTick(mainClkTick), .sysClkTick(sysClkTick),
		.blockClkTick(blockClkTick));
	initial forever #50 clk = ~clk;
	task automatic check(input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("checks=%0d mismatches=%0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic xfer(input logic w, input logic [31:0] a, d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge clk); while (!hreadyout);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (!hreadyout);
	endtask
	task automatic rd(input logic [31:0] a, e);
		expQ.push_back(e);
		xfer(1'b0, a, 32'h0);
	endtask
	// reads are scored in their data phase, apart from whoever issued them
	always @(posedge clk) begin
		if (rdPend) begin
			check(hrdata, expQ.pop_front());
			// the slave never stalls and always answers okay
			check({hreadyout, hresp}, 32'h2);
		end
		rdPend <= hsel && htrans[1] && !hwrite && hreadyout;
	end
	// random source ticks let the checker see each source code routed
	always @(posedge clk) srcTick <= rnd ? 4'($urandom) : 4'hf;
	task automatic cnt(input int n);
		sysCnt = 0;
		foreach (blkCnt[i]) blkCnt[i] = 0;
		repeat (n) begin
			@(posedge clk);
			sysCnt += sysClkTick;
			foreach (blkCnt[i]) blkCnt[i] += blockClkTick[i];
		end
	endtask
	task automatic score(input int nTick, input logic [7:0] g);
		check(sysCnt, nTick);
		foreach (blkCnt[i]) check(blkCnt[i], g[i] ? nTick : 0);
	endtask
	initial begin
		void'($urandom(32'h2165));
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		rd(SRC, 32'h0);
		rd(STB, 32'h1);
		rd(DIV, 32'h1);
		rd(GAT, 32'h3f);
		rd(32'h4004807c, 32'h0);
		xfer(1'b1, GAT, 32'hffffff00);
		rd(GAT, 32'h1);
		rnd <= 1'b1;
		for (int c = 3; c >= 0; c--) begin
			xfer(1'b1, SRC, c);
			rd(SRC, c);
			check(mainSrcActive, c == 3 ? 0 : c + 1);
			xfer(1'b1, STB, 32'hfffffffe);
			rd(STB, 32'h0);
			xfer(1'b1, STB, 32'hffffffff);
			rd(STB, 32'h1);
			check(mainSrcActive, c);
			xfer(1'b1, SRC, ~c);
			rd(SRC, ~c & 3);
			xfer(1'b1, STB, 32'h1);
			@(posedge clk);
			check(mainSrcActive, c);
		end
		rnd <= 1'b0;
		// a window of whole periods makes the tick count exact whatever the phase
		for (int k = 0; k < 5; k++) begin
			gates = 8'($urandom);
			// one pass with the two late-reset gates open, so their enabled path is counted too
			if (k == 1) gates[7:6] = 2'h3;
			xfer(1'b1, GAT, 32'(gates));
			gates[0] = 1'b1;
			xfer(1'b1, DIV, 32'(divs[k]) | 32'hffffff00);
			rd(DIV, divs[k]);
			repeat (520) @(posedge clk);
			cnt(divs[k] == 255 ? 510 : 60);
			expSys = divs[k] == 0 ? 0 : (divs[k] == 255 ? 2 : 60 / divs[k]);
			score(expSys, gates);
		end
		// commit the pending choice, then reset mid-run: every register must fall back
		xfer(1'b1, STB, 32'h0);
		xfer(1'b1, STB, 32'h1);
		@(posedge clk);
		check(mainSrcActive, 32'h3);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		check(mainSrcActive, 32'h0);
		rd(SRC, 32'h0);
		rd(STB, 32'h1);
		rd(DIV, 32'h1);
		rd(GAT, 32'h3f);
		cnt(60);
		score(60, 8'h3f);
		conclude();
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		conclude();
	end
endmodule
bind scg_clock_ctrl scg_clock_ctrl_chk #(.GATE_WIDTH(GATE_WIDTH)) chk (.clk(clk), .sys_rst(sys_rst), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .srcTick(srcTick),
	.mainSrcActive(mainSrcActive), .mainClkTick(mainClkTick), .sysClkTick(sysClkTick), .blockClkTick(blockClkTick));
`default_nettype wire
